/* File: hw/eiic_pkg.sv */
package eiic_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_PEND = 32'hff008500;
  localparam logic [31:0] ADDR_MASK = 32'hff008504;
  localparam logic [31:0] ADDR_CTRL = 32'hff008510;
  localparam logic [31:0] ADDR_MAP0 = 32'hff008520;
  localparam logic [31:0] ADDR_MAP1 = 32'hff008524;
  localparam logic [31:0] ADDR_MAP2 = 32'hff008528;
  // Control register fields
  localparam int CTL_MODE_LO = 0;
  localparam int CTL_DET_LO  = 2;
  localparam int CTL_GIE     = 10;
  localparam int CTL_MO_LO   = 11;
  localparam int CTL_DEB     = 14;
  // Pending and mask bits of the two timer inputs
  localparam int TMR0_BIT = 12;
  localparam int TMR1_BIT = 13;
  // Pin operation modes
  typedef enum logic [1:0] {
    MODE_DED = 2'b00,
    MODE_EXP = 2'b01,
    MODE_MIX = 2'b10,
    MODE_RSV = 2'b11
  } eiic_mode_t;
  // Mask handling applied on hardware interrupt entry
  typedef enum logic [1:0] {
    MO_KEEP = 2'b00,
    MO_DED  = 2'b01,
    MO_EXP  = 2'b10,
    MO_ALL  = 2'b11
  } eiic_mo_t;
  localparam logic [2:0]  MIX_VEC_LOW = 3'h2;  // Forced low vector bits
  localparam int          DEB_LEN     = 3;     // Debounce stable samples
  localparam logic [31:0] RST_VAL     = 32'h0;
endpackage : eiic_pkg

/* File: hw/eiic_top.sv */
`timescale 1ns/10ps
// Contract
// R01 - Mixed: pins 0-4 expanded vector, low 010
// R02 - Mixed: pins 4:1 into map0 low, pin0 latched
// R03 - Software leaves map0 low bits alone
// R04 - Mask bit0 expanded, bits 5-7 dedicated
// R05 - Mixed pending holds only pins 7-5
// R06 - Mask copied to handler slot on service
// R07 - Apply configured mask clear after saving
// R08 - Simultaneous sources count as expanded
// R09 - Software clears mask for expanded priority 31
// R10 - Mask never restored by hardware on return
// R11 - Nonmaskable input edge, synchronised, selectable debounce
// R12 - Dedicated pins level or edge, per pin
// R13 - Global fast/debounce; expanded always debounced
// R14 - Edge sets pending, entry clears it
// R15 - Active level keeps pending set
// R16 - Handler deactivates source then clears pending
// R17 - Debounce needs three stable low samples
// R18 - Source holds request three or seven cycles
// R19 - Six registers at fixed addresses
// R20 - Control register writable and loaded at init
// R21 - Bits 0-1 mode, bits 2-9 detection
// R22 - Bit 10 global enable, not nonmaskable
// R23 - Bits 11-12 mask operation select
// R24 - Bit 14 selects debounce sampling
// R25 - Mode and mask-op encodings fixed in package
module eiic_top
  import eiic_pkg::*;
#(
  parameter int NPIN = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Request pins, active low; timer requests active high
  input  wire logic [NPIN-1:0]   ext_request_n,
  input  wire logic              nmi_n,
  input  wire logic [1:0]        tmr_req,
  // Register port of the core
  input  wire logic [31:0]       reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_rvalid,
  // Control table load at initialization
  input  wire logic              init_ld,
  input  wire logic [31:0]       init_ctrl,
  // Service handshake from the core
  input  wire logic              svc_take,
  input  wire logic              svc_ded,
  input  wire logic              svc_exp,
  input  wire logic [3:0]        svc_bit,
  input  wire logic              svc_nmi,
  // Requests towards arbitration, then the saved mask for the handler
  output logic      [NPIN-1:0]   ded_req,
  output logic      [1:0]        tmr_pend,
  output logic                   exp_req,
  output logic      [7:0]        exp_vec,
  output logic                   nmi_req,
  output logic      [31:0]       handler_saved_mask_slot,
  output logic                   saved_valid
);
  logic [31:0]     pend_r, mask_r, ctrl_r, map0_r, map1_r, map2_r; // Register file
  logic [3:0]      lat_r;        // Low expanded vector bits
  logic [NPIN:0]   flt_r;        // Filtered levels, top bit is nonmaskable
  logic [NPIN:0]   prev_r;       // Previous filtered level
  logic [NPIN:0]   fall;         // Falling edge per channel
  logic [NPIN:0]   smp_in, deb_sel; // Raw pins and debounce select, top bit nonmaskable
  logic [NPIN-1:0] xp;           // Pins in expanded use
  logic [NPIN-1:0] edge_sel;     // Pin uses edge detection
  logic [NPIN-1:0] pend_set;     // Hardware posting per pin
  logic [31:0]     pend_nxt;
  logic [31:0]     mask_nxt;
  logic [7:0]      vec_nxt;
  logic [31:0]     rd_nxt;
  logic            nmi_r;
  eiic_mode_t      mode;
  eiic_mo_t        mo;
  logic            gie, deb;

  assign mode     = eiic_mode_t'(ctrl_r[CTL_MODE_LO +: 2]); // R21 R25
  assign mo       = eiic_mo_t'(ctrl_r[CTL_MO_LO +: 2]);     // R23 R25
  assign gie      = ctrl_r[CTL_GIE];                         // R22
  assign deb      = ctrl_r[CTL_DEB];                         // R24
  assign edge_sel = ctrl_r[CTL_DET_LO +: NPIN];              // R21

  // Expanded pin set per mode; reserved code behaves as dedicated
  always_comb begin
    case (mode)
      MODE_EXP: xp = '1;
      MODE_MIX: xp = NPIN'(8'h1f); // R01
      default:  xp = '0;
    endcase
  end

  // Per-channel inputs gathered so the loop never indexes past a port
  assign smp_in  = {nmi_n, ext_request_n};
  // Expanded pins always debounce so encoder skew is filtered
  assign deb_sel = {deb, {NPIN{deb}} | xp}; // R13 R11

  // Per-channel sampler: two-stage synchroniser, then fast or debounce
  genvar g;
  generate
    for (g = 0; g <= NPIN; g = g + 1) begin : g_smp
      logic             s0_r, s1_r;     // s0 feeds only s1
      logic [DEB_LEN-1:0] hist_r;       // Recent synchronised samples
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s0_r   <= 1'b1;
          s1_r   <= 1'b1;
          hist_r <= '1;
        end else begin
          s0_r   <= smp_in[g];
          s1_r   <= s0_r;
          hist_r <= {hist_r[DEB_LEN-2:0], s1_r};
        end
      end
      // Level changes only after DEB_LEN equal samples when debouncing
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flt_r[g]  <= 1'b1;
          prev_r[g] <= 1'b1;
        end else begin
          prev_r[g] <= flt_r[g];
          if (!deb_sel[g]) begin
            flt_r[g] <= s1_r;
          end else if (hist_r == '0) begin
            flt_r[g] <= 1'b0; // R17
          end else if (hist_r == '1) begin
            flt_r[g] <= 1'b1;
          end
        end
      end
      assign fall[g] = prev_r[g] & ~flt_r[g];
      if (g < NPIN) begin : g_set
        // Edge mode posts on fall, level mode while low
        assign pend_set[g] = ~xp[g] & (edge_sel[g] ? fall[g] : ~flt_r[g]); // R12 R14 R15
      end
    end
  endgenerate

  // Pending register next value; hardware posting wins over any clear
  always_comb begin
    pend_nxt = pend_r;
    if (reg_wr && reg_addr == ADDR_PEND) begin
      pend_nxt = reg_wdata;
      pend_nxt[NPIN-1:0] = (reg_wdata[NPIN-1:0] & ~xp) | (pend_r[NPIN-1:0] & xp); // R05
    end
    if (svc_take && !svc_exp && svc_ded) begin
      pend_nxt[svc_bit] = 1'b0; // R14
    end
    pend_nxt[NPIN-1:0]  = pend_nxt[NPIN-1:0] | pend_set; // R15
    pend_nxt[TMR0_BIT]  = pend_nxt[TMR0_BIT] | tmr_req[0];
    pend_nxt[TMR1_BIT]  = pend_nxt[TMR1_BIT] | tmr_req[1];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= RST_VAL;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Mask: service entry clears after saving, beats a software write
  always_comb begin
    mask_nxt = mask_r;
    if (reg_wr && reg_addr == ADDR_MASK) begin
      mask_nxt = reg_wdata; // R04 R10
    end
    if (svc_take) begin
      case (mo)
        MO_DED:  if (!svc_exp && svc_ded) mask_nxt = RST_VAL; // R07 R08
        MO_EXP:  if (svc_exp) mask_nxt = RST_VAL;               // R07 R08 R09
        MO_ALL:  mask_nxt = RST_VAL;                            // R07
        default: mask_nxt = mask_nxt;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_r <= RST_VAL;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // Saved copy of the mask for the handler frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      handler_saved_mask_slot <= RST_VAL;
      saved_valid             <= 1'b0;
    end else begin
      saved_valid <= svc_take;
      if (svc_take) begin
        handler_saved_mask_slot <= mask_r; // R06
      end
    end
  end

  // Control and map registers; init load beats software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= RST_VAL;
      map1_r <= RST_VAL;
      map2_r <= RST_VAL;
    end else begin
      if (init_ld) begin
        ctrl_r <= init_ctrl; // R20
      end else if (reg_wr && reg_addr == ADDR_CTRL) begin
        ctrl_r <= reg_wdata; // R20
      end
      if (reg_wr && reg_addr == ADDR_MAP1) begin
        map1_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == ADDR_MAP2) begin
        map2_r <= reg_wdata;
      end
    end
  end

  // Expanded vector from filtered pins, pins are inverted data
  always_comb begin
    if (mode == MODE_MIX) begin
      vec_nxt = {~flt_r[4:0], MIX_VEC_LOW}; // R01
    end else begin
      vec_nxt = ~flt_r[7:0];
    end
  end

  // Map 0: low nibble buffers the vector while expanded pins are in use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      map0_r <= RST_VAL;
      lat_r  <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == ADDR_MAP0) begin
        map0_r <= reg_wdata;
      end
      if (xp[0]) begin
        map0_r[3:0] <= vec_nxt[7:4]; // R02 R03
        lat_r       <= vec_nxt[3:0]; // R02
      end
    end
  end

  // Nonmaskable pending: falling edge only, set wins over service
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmi_r <= 1'b0;
    end else if (fall[NPIN]) begin
      nmi_r <= 1'b1; // R11 R12
    end else if (svc_nmi) begin
      nmi_r <= 1'b0;
    end
  end

  // Registered requests; enable bit gates all but the nonmaskable one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ded_req  <= '0;
      tmr_pend <= 2'h0;
      exp_req  <= 1'b0;
      exp_vec  <= 8'h0;
      nmi_req  <= 1'b0;
    end else begin
      ded_req  <= pend_r[NPIN-1:0] & mask_r[NPIN-1:0] & ~xp & {NPIN{gie}}; // R04 R22
      tmr_pend <= {pend_r[TMR1_BIT] & mask_r[TMR1_BIT],
                   pend_r[TMR0_BIT] & mask_r[TMR0_BIT]} & {2{gie}};
      exp_vec  <= {map0_r[3:0], lat_r};
      // Vectors 0 to 7 mean no request
      exp_req  <= xp[0] & (map0_r[3:0] != 4'h0 || lat_r[3]) & mask_r[0] & gie; // R04 R22
      nmi_req  <= nmi_r; // R11
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      ADDR_PEND: rd_nxt = pend_r;
      ADDR_MASK: rd_nxt = mask_r;
      ADDR_CTRL: rd_nxt = ctrl_r;
      ADDR_MAP0: rd_nxt = map0_r;
      ADDR_MAP1: rd_nxt = map1_r;
      ADDR_MAP2: rd_nxt = map2_r;
      default:   rd_nxt = RST_VAL; // R19
    endcase
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= RST_VAL;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata  <= reg_rd ? rd_nxt : reg_rdata;
    end
  end

  property p_save;  // R06
    @(posedge clk) disable iff (rst)
      svc_take |=> saved_valid && handler_saved_mask_slot == $past(mask_r);
  endproperty
  a_save: assert property (p_save) else $error("mask not saved"); // R06
  property p_moall;
    @(posedge clk) disable iff (rst) svc_take && mo == MO_ALL |=> mask_r == '0;
  endproperty
  a_moall: assert property (p_moall) else $error("mask not cleared"); // R07
  property p_expw;
    @(posedge clk) disable iff (rst)
      svc_take && svc_exp && mo == MO_DED && !(reg_wr && reg_addr == ADDR_MASK)
      |=> $stable(mask_r);
  endproperty
  a_expw: assert property (p_expw) else $error("expanded wrongly cleared"); // R08
  property p_lvl;
    @(posedge clk) disable iff (rst)
      !xp[6] && !edge_sel[6] && !flt_r[6] |=> pend_r[6];
  endproperty
  a_lvl: assert property (p_lvl) else $error("level pending lost"); // R15
  property p_nmi;
    @(posedge clk) disable iff (rst) fall[NPIN] |=> ##1 nmi_req;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi missed"); // R11
  property p_deb;
    @(posedge clk) disable iff (rst)
      deb_sel[4] && $fell(flt_r[4]) |-> $past(g_smp[4].hist_r) == '0;
  endproperty
  a_deb: assert property (p_deb) else $error("debounce too early"); // R17
  property p_gie;
    @(posedge clk) disable iff (rst) !gie |=> ded_req == '0 && !exp_req;
  endproperty
  a_gie: assert property (p_gie) else $error("enable ignored"); // R22
  property p_mixp;
    @(posedge clk) disable iff (rst)
      mode == MODE_MIX && $past(mode) == MODE_MIX |-> $stable(pend_r[4:0]);
  endproperty
  a_mixp: assert property (p_mixp) else $error("mixed pending moved"); // R05
  c_svc: cover property (@(posedge clk) svc_take && svc_exp);
  c_nmi: cover property (@(posedge clk) nmi_req);
  c_mix: cover property (@(posedge clk) mode == MODE_MIX && exp_req);
endmodule : eiic_top

/* File: verification/eiic_src_model.sv */
`timescale 1ns/10ps
// Far-side requesters; released pins return high (pull-ups)
module eiic_src_model (
  // Clock
  input  wire logic       clk,
  // Request pins, active low
  output logic      [7:0] ext_request_n,
  output logic            nmi_n
);
  initial begin
    ext_request_n = 8'hff;
    nmi_n         = 1'b1;
  end
  // Low pulse long enough for fast sampling
  task pulse_pin(input int p, input int n);
    @(posedge clk);
    ext_request_n[p] <= 1'b0;
    repeat (n) @(posedge clk);
    ext_request_n[p] <= 1'b1;
  endtask : pulse_pin
  // Level source held until told otherwise
  task set_pin(input int p, input logic v);
    @(posedge clk);
    ext_request_n[p] <= v;
  endtask : set_pin
  // Encoder output: inverse of vector bits 7..3
  task put_vec(input logic [7:0] v);
    @(posedge clk);
    ext_request_n[4:0] <= ~v[7:3];
  endtask : put_vec
  // Source cleared after service
  task release_all;
    @(posedge clk);
    ext_request_n <= 8'hff;
  endtask : release_all
  // Falling edge on the nonmaskable pin
  task nmi_fall;
    @(posedge clk);
    nmi_n <= 1'b0;
    repeat (7) @(posedge clk);
    nmi_n <= 1'b1;
  endtask : nmi_fall
endmodule : eiic_src_model

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import eiic_pkg::*;
  // Stimulus
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  tmr_req = 2'h0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] init_ctrl = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        init_ld = 1'b0;
  logic        svc_take = 1'b0;
  logic        svc_ded = 1'b0;
  logic        svc_exp = 1'b0;
  logic        svc_nmi = 1'b0;
  logic [3:0]  svc_bit = 4'h0;
  // Observed
  logic [7:0]  ext_request_n, ded_req, exp_vec;
  logic [1:0]  tmr_pend;
  logic        nmi_n, reg_rvalid, exp_req, nmi_req, saved_valid;
  logic [31:0] reg_rdata, slot;
  int          num_errors = 0;
  int          n_checks = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  eiic_src_model i_src (.clk(clk), .ext_request_n(ext_request_n), .nmi_n(nmi_n));
  eiic_top #(.NPIN(8)) i_dut (
    .clk(clk), .rst(rst), .ext_request_n(ext_request_n), .nmi_n(nmi_n),
    .tmr_req(tmr_req), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .init_ld(init_ld), .init_ctrl(init_ctrl), .svc_take(svc_take),
    .svc_ded(svc_ded), .svc_exp(svc_exp), .svc_bit(svc_bit), .svc_nmi(svc_nmi),
    .ded_req(ded_req), .tmr_pend(tmr_pend), .exp_req(exp_req), .exp_vec(exp_vec),
    .nmi_req(nmi_req), .handler_saved_mask_slot(slot), .saved_valid(saved_valid)
  );
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Verdict
  task end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  // Register write, one-cycle strobe
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Register read; data valid the cycle after the strobe
  task rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, e);
  endtask : rd
  // Handler entry pulse, then the saved mask
  task svc(input logic d, input logic x, input logic [3:0] b, input logic [31:0] m);
    @(posedge clk);
    svc_take <= 1'b1;
    svc_ded  <= d;
    svc_exp  <= x;
    svc_bit  <= b;
    @(posedge clk);
    svc_take <= 1'b0;
    #1 chk({31'h0, saved_valid}, 32'h1);
    chk(slot, m);
  endtask : svc
  // Bounded wait: 0 expanded, 1 pin 5, 2 nonmaskable
  task wait_for(input int s);
    int k;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      if ((s == 0 && exp_req === 1'b1) || (s == 1 && ded_req[5] === 1'b1)
          || (s == 2 && nmi_req === 1'b1)) break;
    end
    if (k == 40) begin
      num_errors++;
      $display("Error at %0t: request never seen", $time);
      end_sim;
    end
  endtask : wait_for
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_MASK, RST_VAL);
    rd(32'hff00850c, 32'h0);
    wr(ADDR_MAP1, 32'h0000abcd);
    rd(ADDR_MAP1, 32'h0000abcd);
    @(posedge clk);
    init_ctrl <= 32'h00004000;
    init_ld   <= 1'b1;
    @(posedge clk);
    init_ld <= 1'b0;
    rd(ADDR_CTRL, 32'h00004000);
    $display("test registers done");
    // Dedicated: pin 5 edge, pin 6 level, mask cleared for dedicated
    wr(ADDR_CTRL, 32'h00000c80);
    wr(ADDR_MASK, 32'h00000060);
    i_src.pulse_pin(5, 3);
    wait_for(1);
    rd(ADDR_PEND, 32'h00000020);
    svc(1'b1, 1'b0, 4'h5, 32'h00000060);
    rd(ADDR_MASK, 32'h0);
    rd(ADDR_PEND, 32'h0);
    i_src.set_pin(6, 1'b0);
    repeat (8) @(posedge clk);
    svc(1'b1, 1'b0, 4'h6, 32'h0);
    wr(ADDR_PEND, 32'h0);
    rd(ADDR_PEND, 32'h00000040);
    i_src.set_pin(6, 1'b1);
    repeat (8) @(posedge clk);
    wr(ADDR_PEND, 32'h0);
    rd(ADDR_PEND, 32'h0);
    // Timer posting reaches its output only through its mask bit and the enable
    wr(ADDR_MASK, 32'h00001000);
    @(posedge clk);
    tmr_req <= 2'h1;
    @(posedge clk);
    tmr_req <= 2'h0;
    rd(ADDR_PEND, 32'h00001000);
    chk({30'h0, tmr_pend}, 32'h1);
    wr(ADDR_PEND, 32'h0);
    $display("test dedicated done");
    // Mixed: upper map bits set first, hardware then owns the low nibble
    wr(ADDR_MAP0, 32'h00000050);
    wr(ADDR_CTRL, 32'h00001402);
    wr(ADDR_MASK, 32'h000000e1);
    i_src.put_vec(8'ha2);
    wait_for(0);
    chk({24'h0, exp_vec}, 32'h000000a2);
    rd(ADDR_MAP0, 32'h0000005a);
    wr(ADDR_PEND, 32'h0000001f);
    rd(ADDR_PEND, 32'h0);
    svc(1'b1, 1'b1, 4'h5, 32'h000000e1);
    rd(ADDR_MASK, 32'h0);
    // Both sources under dedicated-only clearing count as expanded: mask kept
    wr(ADDR_CTRL, 32'h00000c02);
    wr(ADDR_MASK, 32'h000000e1);
    svc(1'b1, 1'b1, 4'h5, 32'h000000e1);
    rd(ADDR_MASK, 32'h000000e1);
    i_src.release_all;
    $display("test mixed done");
    // Nonmaskable edge, cleared by its own entry
    i_src.nmi_fall;
    wait_for(2);
    @(posedge clk);
    svc_nmi <= 1'b1;
    @(posedge clk);
    svc_nmi <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({31'h0, nmi_req}, 32'h0);
    $display("test nonmaskable done");
    end_sim;
  end
endmodule : testbench
